// ===== inc/mio_pkg.sv
// Constants, register map and field layout of the machine I/O block
package mio_pkg;
  localparam int CLK_MHZ = 100;
  localparam int DEB_US  = 1000;
  localparam int DEB_CYC = DEB_US * CLK_MHZ;
  localparam int SEC_US  = 1000000;
  localparam int SEC_CYC = SEC_US * CLK_MHZ;
  localparam int NPRESS  = 2;
  localparam int NIN     = 10;
  localparam int NOUT    = 11;
  // Input vector positions
  localparam int I_JA    = 0;
  localparam int I_JB    = 1;
  localparam int I_RUN   = 2;
  localparam int I_SB    = 3;
  localparam int I_LOCK  = 4;
  localparam int I_CUT   = 5;
  localparam int I_PRS   = 6;
  localparam int I_MAT   = 7;
  localparam int I_PB    = 8;
  // Output vector positions
  localparam int O_FAST  = 0;
  localparam int O_SLOW  = 1;
  localparam int O_REV   = 2;
  localparam int O_SHEAR = 3;
  localparam int O_RUN   = 4;
  localparam int O_PRESS = 5;
  localparam int O_FWD   = 7;
  localparam int O_SPUSH = 8;
  localparam int O_PPUSH = 9;
  localparam int O_ITEM  = 10;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_MODE   = 8'h04;
  localparam logic [7:0] OFS_SDWELL = 8'h08;
  localparam logic [7:0] OFS_PDWELL = 8'h0C;
  localparam logic [7:0] OFS_IDWELL = 8'h10;
  localparam logic [7:0] OFS_HALT   = 8'h14;
  localparam logic [7:0] OFS_TIME   = 8'h18;
  localparam logic [7:0] OFS_DATE   = 8'h1C;
  localparam logic [7:0] OFS_HTIME  = 8'h20;
  localparam logic [7:0] OFS_HDATE  = 8'h24;
  localparam logic [7:0] OFS_FMT    = 8'h28;
  localparam logic [7:0] OFS_STATUS = 8'h2C;
  // Field positions
  localparam int C_ORDER = 0;
  localparam int C_ALARM = 1;
  localparam int C_ITEM  = 2;
  localparam int C_CUT   = 3;
  localparam int C_PRESS = 4;
  localparam int C_HOST  = 6;
  localparam int M_TWO   = 0;
  localparam int M_PUSH  = 1;
  localparam int T_SEC   = 0;
  localparam int T_MIN   = 8;
  localparam int T_HOUR  = 16;
  localparam int D_DAY   = 0;
  localparam int D_MON   = 8;
  localparam int D_YEAR  = 16;
  localparam int F_TOG   = 0;
  localparam int F_ACT   = 1;
  localparam int S_IN    = 0;
  localparam int S_OUT   = 10;
  localparam int S_RUN   = 21;
  localparam int S_ERR   = 22;
  // Masks and reset values
  localparam logic [31:0] CTRL_MASK = 32'h0000_0043;
  localparam logic [31:0] MODE_MASK = 32'h0000_0003;
  localparam logic [31:0] HALT_MASK = 32'h0007_FFFF;
  localparam logic [31:0] RST_DWELL = 32'h0000_0064;
  localparam logic [4:0]  RST_DAY   = 5'h01;
  localparam logic [3:0]  RST_MON   = 4'h1;
  localparam logic [11:0] RST_YEAR  = 12'h7D0;
endpackage : mio_pkg

// ===== hdl/mio_debounce.sv
// Three-stage synchroniser and per-bit debounce filter
module mio_debounce #(
  parameter int N   = 1,
  parameter int CYC = 2
) (
  input  wire logic         mclk_i,
  input  wire logic         reset_i,
  input  wire logic [N-1:0] raw_i,
  output logic      [N-1:0] clean_o
);
  localparam int CW = $clog2(CYC + 1);
  logic [N-1:0]  s1_r, s2_r, s3_r, cl_r, cl_nxt;
  logic [CW-1:0] cnt_r [N];
  logic [CW-1:0] cnt_nxt [N];

  // A level counts only once stages two and three agree for CYC cycles
  always_comb begin
    for (int k = 0; k < N; k++) begin
      cl_nxt[k]  = cl_r[k];
      cnt_nxt[k] = '0;
      if (s2_r[k] == s3_r[k] && s3_r[k] != cl_r[k]) begin
        if (cnt_r[k] == CW'(CYC - 1)) begin
          cl_nxt[k] = s3_r[k];
        end else begin
          cnt_nxt[k] = cnt_r[k] + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      cl_r <= '0;
      for (int k = 0; k < N; k++) cnt_r[k] <= '0;
    end else begin
      s1_r <= raw_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      cl_r <= cl_nxt;
      for (int k = 0; k < N; k++) cnt_r[k] <= cnt_nxt[k];
    end
  end

  assign clean_o = cl_r;
endmodule : mio_debounce

// ===== hdl/mio_dwell.sv
// Timed solenoid pulse with early end on bottom of stroke
module mio_dwell (
  input  wire logic        mclk_i,
  input  wire logic        reset_i,
  input  wire logic        start_i,
  input  wire logic        stop_i,
  input  wire logic [31:0] dwell_i,
  output logic             on_o
);
  logic        on_r, on_nxt;
  logic [31:0] cnt_r, cnt_nxt;

  // Stop beats start so a late bottom pulse never retriggers
  always_comb begin
    on_nxt  = on_r;
    cnt_nxt = cnt_r;
    if (stop_i) begin
      on_nxt  = 1'b0;
      cnt_nxt = '0;
    end else if (on_r) begin
      if (cnt_r + 32'd1 >= dwell_i) begin
        on_nxt  = 1'b0;
        cnt_nxt = '0;
      end else begin
        cnt_nxt = cnt_r + 32'd1;
      end
    end else if (start_i) begin
      on_nxt  = 1'b1;
      cnt_nxt = '0;
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      on_r  <= 1'b0;
      cnt_r <= '0;
    end else begin
      on_r  <= on_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign on_o = on_r;
endmodule : mio_dwell

// ===== hdl/mio_io_ctrl.sv
// Machine discrete I/O control with Wishbone registers
module mio_io_ctrl #(
  parameter int DEB_CYC = mio_pkg::DEB_CYC,
  parameter int SEC_CYC = mio_pkg::SEC_CYC
) (
  input  wire logic                      mclk_i,
  input  wire logic                      reset_i,
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [7:0]                wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [31:0]               wb_dat_i,
  output logic      [31:0]               wb_dat_o,
  output logic                           wb_ack_o,
  input  wire logic                      jog_ahead_in_n_i,
  input  wire logic                      jog_back_in_n_i,
  input  wire logic                      run_in_n_i,
  input  wire logic                      shear_bottom_in_n_i,
  input  wire logic                      lockout_in_n_i,
  input  wire logic                      hand_cut_in_n_i,
  input  wire logic                      hand_press_in_n_i,
  input  wire logic                      material_in_i,
  input  wire logic [mio_pkg::NPRESS-1:0] press_bottom_in_n_i,
  output logic                           fast_o,
  output logic                           slow_o,
  output logic                           reverse_o,
  output logic                           forward_o,
  output logic                           run_o,
  output logic                           shear_down_o,
  output logic      [mio_pkg::NPRESS-1:0] press_down_o,
  output logic                           shear_die_push_out_o,
  output logic                           press_die_push_out_o,
  output logic                           line_item_done_out_o
);
  localparam int PW = $clog2(SEC_CYC);

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) r[8*b +: 8] = nw[8*b +: 8];
    end
    return r;
  endfunction : merge

  function automatic logic rise(input logic now, input logic was);
    return now & ~was;
  endfunction : rise

  function automatic logic [4:0] dim(input logic [3:0]  m,
                                     input logic [11:0] y);
    if (m == 4'h2) return (y[1:0] == 2'b00) ? 5'd29 : 5'd28;
    if (m == 4'h4 || m == 4'h6 || m == 4'h9 || m == 4'hB) return 5'd30;
    return 5'd31;
  endfunction : dim

  // Inputs: pins read 0 when closed to common, except material_in_i which is taken active high
  logic [mio_pkg::NIN-1:0] raw, in_c, in_p_r;
  assign raw = {~press_bottom_in_n_i,
                material_in_i,
                ~hand_press_in_n_i, ~hand_cut_in_n_i, ~lockout_in_n_i,
                ~shear_bottom_in_n_i, ~run_in_n_i, ~jog_back_in_n_i,
                ~jog_ahead_in_n_i};

  mio_debounce #(.N(mio_pkg::NIN), .CYC(DEB_CYC)) u_deb (
    .mclk_i  (mclk_i),
    .reset_i (reset_i),
    .raw_i   (raw),
    .clean_o (in_c)
  );

  // Bus slave: one wait state, unmapped reads return zero
  logic        ack_r, ack_nxt, req, wr;
  logic [31:0] rd_r, rd_nxt, wdat;
  assign req = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wr  = req & wb_we_i;

  logic [31:0] ctrl_r, ctrl_nxt, mode_r, mode_nxt, halt_r, halt_nxt;
  logic [31:0] sdw_r, sdw_nxt, pdw_r, pdw_nxt, idw_r, idw_nxt;
  logic        err_r, err_nxt, prot_wr, locked;
  logic        fpend_r, fpend_nxt, fact_r, fact_nxt;
  logic        item_go, cut_go;
  logic [mio_pkg::NPRESS-1:0] press_go;

  logic [5:0]    sec_r, sec_nxt, min_r, min_nxt;
  logic [4:0]    hour_r, hour_nxt, day_r, day_nxt;
  logic [3:0]    mon_r, mon_nxt;
  logic [11:0]   year_r, year_nxt;
  logic [PW-1:0] pre_r, pre_nxt;
  logic [31:0]   tword, dword;
  logic          set_t, set_d, tick;
  logic [mio_pkg::NOUT-1:0] out_r, out_nxt;

  assign tword = {11'h0, hour_r, 2'h0, min_r, 2'h0, sec_r};
  assign dword = {4'h0, year_r, 4'h0, mon_r, 3'h0, day_r};
  assign locked = in_c[mio_pkg::I_LOCK];

  always_comb begin
    wdat = '0;
    unique case (wb_adr_i)
      mio_pkg::OFS_CTRL:   wdat = ctrl_r;
      mio_pkg::OFS_MODE:   wdat = mode_r;
      mio_pkg::OFS_SDWELL: wdat = sdw_r;
      mio_pkg::OFS_PDWELL: wdat = pdw_r;
      mio_pkg::OFS_IDWELL: wdat = idw_r;
      mio_pkg::OFS_HALT:   wdat = halt_r;
      mio_pkg::OFS_TIME,
      mio_pkg::OFS_HTIME:  wdat = tword;
      mio_pkg::OFS_DATE,
      mio_pkg::OFS_HDATE:  wdat = dword;
      mio_pkg::OFS_FMT:    wdat = {30'h0, fact_r, fpend_r};
      mio_pkg::OFS_STATUS: wdat = {9'h0, err_r, out_r[mio_pkg::O_RUN],
                                   out_r, in_c};
      default:             wdat = '0;
    endcase
    ack_nxt = req;
    rd_nxt  = req ? wdat : rd_r;
    wdat    = merge(wdat, wb_dat_i, wb_sel_i);
  end

  // Setup registers; lockout protects only the mode and dwell registers
  always_comb begin
    ctrl_nxt  = ctrl_r;
    mode_nxt  = mode_r;
    sdw_nxt   = sdw_r;
    pdw_nxt   = pdw_r;
    idw_nxt   = idw_r;
    halt_nxt  = halt_r;
    fpend_nxt = fpend_r;
    fact_nxt  = fact_r;
    item_go   = 1'b0;
    cut_go    = 1'b0;
    press_go  = '0;
    prot_wr   = wr & (wb_adr_i == mio_pkg::OFS_MODE ||
                      wb_adr_i == mio_pkg::OFS_SDWELL ||
                      wb_adr_i == mio_pkg::OFS_PDWELL ||
                      wb_adr_i == mio_pkg::OFS_IDWELL);
    // Error flag: a new rejection wins over a clear in the same cycle
    err_nxt = (err_r & ~(wr & wb_adr_i == mio_pkg::OFS_STATUS &
                         wdat[mio_pkg::S_ERR])) |
              (prot_wr & locked);
    if (wr) begin
      unique case (wb_adr_i)
        mio_pkg::OFS_CTRL: begin
          ctrl_nxt = wdat & mio_pkg::CTRL_MASK;
          item_go  = wb_sel_i[0] & wb_dat_i[mio_pkg::C_ITEM];
          cut_go   = wb_sel_i[0] & wb_dat_i[mio_pkg::C_CUT];
          press_go = {mio_pkg::NPRESS{wb_sel_i[0]}} &
                     wb_dat_i[mio_pkg::C_PRESS +: mio_pkg::NPRESS];
        end
        mio_pkg::OFS_MODE:   if (!locked) mode_nxt = wdat & mio_pkg::MODE_MASK;
        mio_pkg::OFS_SDWELL: if (!locked) sdw_nxt = wdat;
        mio_pkg::OFS_PDWELL: if (!locked) pdw_nxt = wdat;
        mio_pkg::OFS_IDWELL: if (!locked) idw_nxt = wdat;
        mio_pkg::OFS_HALT:   halt_nxt = wdat & mio_pkg::HALT_MASK;
        mio_pkg::OFS_FMT: begin
          // Confirm commits the choice shown before this write's toggle
          if (wdat[mio_pkg::F_ACT]) fact_nxt = fpend_r;
          if (wdat[mio_pkg::F_TOG]) fpend_nxt = ~fpend_r;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      ack_r   <= 1'b0;
      rd_r    <= '0;
      ctrl_r  <= '0;
      mode_r  <= '0;
      sdw_r   <= mio_pkg::RST_DWELL;
      pdw_r   <= mio_pkg::RST_DWELL;
      idw_r   <= mio_pkg::RST_DWELL;
      halt_r  <= '0;
      err_r   <= 1'b0;
      fpend_r <= 1'b0;
      fact_r  <= 1'b0;
    end else begin
      ack_r   <= ack_nxt;
      rd_r    <= rd_nxt;
      ctrl_r  <= ctrl_nxt;
      mode_r  <= mode_nxt;
      sdw_r   <= sdw_nxt;
      pdw_r   <= pdw_nxt;
      idw_r   <= idw_nxt;
      halt_r  <= halt_nxt;
      err_r   <= err_nxt;
      fpend_r <= fpend_nxt;
      fact_r  <= fact_nxt;
    end
  end

  // Calendar clock; a write suppresses the pending tick
  always_comb begin
    set_t = wr & ((wb_adr_i == mio_pkg::OFS_TIME &
                   ~ctrl_r[mio_pkg::C_HOST]) |
                  wb_adr_i == mio_pkg::OFS_HTIME);
    set_d = wr & ((wb_adr_i == mio_pkg::OFS_DATE &
                   ~ctrl_r[mio_pkg::C_HOST]) |
                  wb_adr_i == mio_pkg::OFS_HDATE);
    tick     = pre_r == PW'(SEC_CYC - 1);
    sec_nxt  = sec_r;
    min_nxt  = min_r;
    hour_nxt = hour_r;
    day_nxt  = day_r;
    mon_nxt  = mon_r;
    year_nxt = year_r;
    pre_nxt  = pre_r + 1'b1;
    if (set_t || set_d) begin
      pre_nxt = '0;
      if (set_t) begin
        sec_nxt  = wdat[mio_pkg::T_SEC +: 6];
        min_nxt  = wdat[mio_pkg::T_MIN +: 6];
        hour_nxt = wdat[mio_pkg::T_HOUR +: 5];
      end
      if (set_d) begin
        day_nxt  = wdat[mio_pkg::D_DAY +: 5];
        mon_nxt  = wdat[mio_pkg::D_MON +: 4];
        year_nxt = wdat[mio_pkg::D_YEAR +: 12];
      end
    end else if (tick) begin
      pre_nxt = '0;
      sec_nxt = sec_r + 1'b1;
      if (sec_r >= 6'd59) begin
        sec_nxt = '0;
        min_nxt = min_r + 1'b1;
        if (min_r >= 6'd59) begin
          min_nxt  = '0;
          hour_nxt = hour_r + 1'b1;
          if (hour_r >= 5'd23) begin
            hour_nxt = '0;
            day_nxt  = day_r + 1'b1;
            if (day_r >= dim(mon_r, year_r)) begin
              day_nxt = 5'd1;
              mon_nxt = mon_r + 1'b1;
              if (mon_r >= 4'd12) begin
                mon_nxt  = 4'd1;
                year_nxt = year_r + 1'b1;
              end
            end
          end
        end
      end
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      sec_r  <= '0;
      min_r  <= '0;
      hour_r <= '0;
      day_r  <= mio_pkg::RST_DAY;
      mon_r  <= mio_pkg::RST_MON;
      year_r <= mio_pkg::RST_YEAR;
      pre_r  <= '0;
    end else begin
      sec_r  <= sec_nxt;
      min_r  <= min_nxt;
      hour_r <= hour_nxt;
      day_r  <= day_nxt;
      mon_r  <= mon_nxt;
      year_r <= year_nxt;
      pre_r  <= pre_nxt;
    end
  end

  // Dwell timers for shear, presses and item complete
  logic                       sh_on, item_on;
  logic [mio_pkg::NPRESS-1:0] pr_on;

  mio_dwell u_shear (
    .mclk_i  (mclk_i),
    .reset_i (reset_i),
    .start_i (cut_go | rise(in_c[mio_pkg::I_CUT],
                            in_p_r[mio_pkg::I_CUT])),
    .stop_i  (rise(in_c[mio_pkg::I_SB], in_p_r[mio_pkg::I_SB])),
    .dwell_i (sdw_r),
    .on_o    (sh_on)
  );

  for (genvar k = 0; k < mio_pkg::NPRESS; k++) begin : g_press
    mio_dwell u_press (
      .mclk_i  (mclk_i),
      .reset_i (reset_i),
      .start_i (press_go[k] | rise(in_c[mio_pkg::I_PRS],
                                   in_p_r[mio_pkg::I_PRS])),
      .stop_i  (rise(in_c[mio_pkg::I_PB + k],
                     in_p_r[mio_pkg::I_PB + k])),
      .dwell_i (pdw_r),
      .on_o    (pr_on[k])
    );
  end

  mio_dwell u_item (
    .mclk_i  (mclk_i),
    .reset_i (reset_i),
    .start_i (item_go),
    .stop_i  (1'b0),
    .dwell_i (idw_r),
    .on_o    (item_on)
  );

  // Movement drive; jog only acts while not running
  logic run_ok, jf, jr;
  always_comb begin
    run_ok = in_c[mio_pkg::I_RUN] & ctrl_r[mio_pkg::C_ORDER] &
             ~ctrl_r[mio_pkg::C_ALARM];
    jf = ~run_ok & in_c[mio_pkg::I_JA] & ~in_c[mio_pkg::I_JB];
    jr = ~run_ok & in_c[mio_pkg::I_JB] & ~in_c[mio_pkg::I_JA];
    out_nxt = '0;
    out_nxt[mio_pkg::O_FAST]  = run_ok | ((jf | jr) & ~mode_r[mio_pkg::M_TWO]);
    out_nxt[mio_pkg::O_SLOW]  = (jf | jr) & mode_r[mio_pkg::M_TWO];
    out_nxt[mio_pkg::O_REV]   = jr;
    out_nxt[mio_pkg::O_FWD]   = run_ok | jf;
    out_nxt[mio_pkg::O_RUN]   = run_ok;
    out_nxt[mio_pkg::O_SHEAR] = sh_on;
    out_nxt[mio_pkg::O_PRESS +: mio_pkg::NPRESS] = pr_on;
    out_nxt[mio_pkg::O_SPUSH] = sh_on & mode_r[mio_pkg::M_PUSH];
    out_nxt[mio_pkg::O_PPUSH] = (|pr_on) & mode_r[mio_pkg::M_PUSH];
    out_nxt[mio_pkg::O_ITEM]  = item_on;
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      out_r  <= '0;
      in_p_r <= '0;
    end else begin
      out_r  <= out_nxt;
      in_p_r <= in_c;
    end
  end

  // Same flops feed pins and status; a status read returns the drive as registered the cycle before its ack
  assign fast_o               = out_r[mio_pkg::O_FAST];
  assign slow_o               = out_r[mio_pkg::O_SLOW];
  assign reverse_o            = out_r[mio_pkg::O_REV];
  assign forward_o            = out_r[mio_pkg::O_FWD];
  assign run_o                = out_r[mio_pkg::O_RUN];
  assign shear_down_o         = out_r[mio_pkg::O_SHEAR];
  assign press_down_o         = out_r[mio_pkg::O_PRESS +: mio_pkg::NPRESS];
  assign shear_die_push_out_o = out_r[mio_pkg::O_SPUSH];
  assign press_die_push_out_o = out_r[mio_pkg::O_PPUSH];
  assign line_item_done_out_o = out_r[mio_pkg::O_ITEM];
  assign wb_ack_o             = ack_r;
  assign wb_dat_o             = rd_r;

  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  a_run_stop: assert property (
    !in_c[mio_pkg::I_RUN] |=> !run_o)
    else $error("run output without run input");
  a_run_gate: assert property (
    run_o |-> $past(ctrl_r[mio_pkg::C_ORDER] & ~ctrl_r[mio_pkg::C_ALARM]))
    else $error("run entered without order or with alarm");
  a_shear_early: assert property (
    rise(in_c[mio_pkg::I_SB], in_p_r[mio_pkg::I_SB]) |-> ##2 !shear_down_o)
    else $error("shear down not removed on bottom");
  a_press_early: assert property (
    rise(in_c[mio_pkg::I_PB], in_p_r[mio_pkg::I_PB]) |-> ##2 !press_down_o[0])
    else $error("press down not removed on bottom");
  a_lock_reject: assert property (
    wr && wb_adr_i == mio_pkg::OFS_SDWELL && locked
    |=> $stable(sdw_r) && err_r)
    else $error("protected write accepted under lockout");
  a_halt_free: assert property (
    wr && wb_adr_i == mio_pkg::OFS_HALT && wb_sel_i == 4'hF
    |=> halt_r == ($past(wb_dat_i) & mio_pkg::HALT_MASK))
    else $error("halt settings write lost");
  a_jog_fwd: assert property (
    forward_o && !run_o |-> $past(in_c[mio_pkg::I_JA]))
    else $error("forward drive without jog ahead");
  a_time_restart: assert property (
    set_t && wb_sel_i == 4'hF
    |=> pre_r == '0 && sec_r == $past(wb_dat_i[5:0]))
    else $error("clock did not restart from written time");
  a_host_over: assert property (
    wr && wb_adr_i == mio_pkg::OFS_TIME && ctrl_r[mio_pkg::C_HOST] && !tick
    && wb_adr_i != mio_pkg::OFS_HTIME |=> $stable(sec_r) && pre_r != '0)
    else $error("local time write took effect under host link");
  a_status_view: assert property (
    wb_ack_o && $past(wb_adr_i) == mio_pkg::OFS_STATUS && !$past(wb_we_i)
    |-> wb_dat_o[mio_pkg::S_OUT +: mio_pkg::NOUT] == $past(out_r))
    else $error("status read does not show output drive");
endmodule : mio_io_ctrl

// ===== tb/mio_plant.sv
// Plant model: operator switches, sensors and bottom-of-stroke switches
module mio_plant (
  input  wire logic       mclk_i,
  input  wire logic [9:0] sw_i,
  input  wire logic       bot_en_i,
  input  wire logic       shear_i,
  input  wire logic [1:0] press_i,
  output logic      [9:0] pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] bot_r;
  // Die reaches bottom a cycle after its solenoid pulls in
  always_ff @(posedge mclk_i) begin
    bot_r <= {3{bot_en_i}} & {press_i, shear_i};
  end
  // Closed contact pulls the pin to common, except the material pin 7 which follows its switch high
  always_comb begin
    pin_o      = ~sw_i;
    pin_o[7]   = sw_i[7];
    pin_o[3]   = ~(sw_i[3] | bot_r[0]);
    pin_o[9:8] = ~(sw_i[9:8] | bot_r[2:1]);
  end
endmodule : mio_plant

// ===== tb/machine_io_control_bench.sv
// Self-checking bench for the machine I/O control block
module machine_io_control_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk_i = 0, reset_i = 1, cyc = 0, stb = 0, we = 0;
  logic        bot_en = 0, ack, fast, slow, rev, fwd, run, shr;
  logic        spush, ppush, item;
  logic [7:0]  adr = '0;
  logic [31:0] dat = '0, rdat, q;
  logic [9:0]  sw = '0, pin;
  logic [1:0]  pd;
  logic [10:0] outv;
  int          errors = 0, total_checks = 0, len;
  always #5 mclk_i = ~mclk_i;
  assign outv = {item, ppush, spush, fwd, pd, run, shr, rev, slow, fast};
  mio_plant plant (.mclk_i(mclk_i), .sw_i(sw), .bot_en_i(bot_en),
    .shear_i(shr), .press_i(pd), .pin_o(pin));
  mio_io_ctrl #(.DEB_CYC(4), .SEC_CYC(20)) dut (.mclk_i(mclk_i),
    .reset_i(reset_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .jog_ahead_in_n_i(pin[0]), .jog_back_in_n_i(pin[1]),
    .run_in_n_i(pin[2]), .shear_bottom_in_n_i(pin[3]),
    .lockout_in_n_i(pin[4]), .hand_cut_in_n_i(pin[5]),
    .hand_press_in_n_i(pin[6]), .material_in_i(pin[7]),
    .press_bottom_in_n_i(pin[9:8]), .fast_o(fast), .slow_o(slow),
    .reverse_o(rev), .forward_o(fwd), .run_o(run), .shear_down_o(shr),
    .press_down_o(pd), .shear_die_push_out_o(spush),
    .press_die_push_out_o(ppush), .line_item_done_out_o(item));
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge mclk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) errors++;
    q = rdat;
    cyc <= 0;
    stb <= 0;
    @(posedge mclk_i);
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask : wr
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0000_0000);
    chk(nm, q, e);
  endtask : rc
  task automatic wt(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : wt
  // Counts the cycles an output stays high after it first rises
  task automatic width(input int b);
    int n;
    n = 0;
    len = 0;
    while (outv[b] !== 1'b1 && n < 40) begin
      @(posedge mclk_i);
      n++;
    end
    while (outv[b] === 1'b1 && len < 200) begin
      @(posedge mclk_i);
      len++;
    end
  endtask : width
  initial begin
    #100000;
    errors++;
    print_verdict();
  end
  initial begin
    wt(2);
    reset_i <= 0;
    wt(1);
    sw <= 10'h084;
    wt(15);
    rc("inputs", mio_pkg::OFS_STATUS, 32'h0000_0084);
    chk("run idle", run, 1'b0);
    wr(mio_pkg::OFS_CTRL, 32'h0000_0001);
    wt(3);
    chk("run", run, 1'b1);
    rc("status", mio_pkg::OFS_STATUS, 32'h0022_4484);
    wr(mio_pkg::OFS_CTRL, 32'h0000_0003);
    wt(3);
    chk("run alarm", run, 1'b0);
    wr(mio_pkg::OFS_CTRL, 32'h0000_0001);
    sw <= 10'h080;
    wt(15);
    chk("run open", run, 1'b0);
    sw <= 10'h081;
    wt(15);
    chk("jog ahead", outv, 11'h081);
    sw <= 10'h082;
    wt(15);
    chk("jog back", outv, 11'h005);
    sw <= 10'h080;
    wt(15);
    wr(mio_pkg::OFS_MODE, 32'h0000_0003);
    sw <= 10'h081;
    wt(15);
    chk("jog slow", outv, 11'h082);
    sw <= 10'h080;
    wt(15);
    wr(mio_pkg::OFS_SDWELL, 32'h0000_0032);
    wr(mio_pkg::OFS_PDWELL, 32'h0000_0032);
    bot_en <= 1;
    fork wr(mio_pkg::OFS_CTRL, 32'h0000_0008); width(mio_pkg::O_SHEAR); join
    chk("shear early", len > 0 && len < 50, 1'b1);
    fork wr(mio_pkg::OFS_CTRL, 32'h0000_0030); width(mio_pkg::O_PRESS); join
    chk("press early", len > 0 && len < 50, 1'b1);
    bot_en <= 0;
    wr(mio_pkg::OFS_SDWELL, 32'h0000_0005);
    wr(mio_pkg::OFS_IDWELL, 32'h0000_0003);
    fork wr(mio_pkg::OFS_CTRL, 32'h0000_0008); width(mio_pkg::O_SHEAR); join
    chk("shear dwell", len, 5);
    fork wr(mio_pkg::OFS_CTRL, 32'h0000_0008); width(mio_pkg::O_SPUSH); join
    chk("shear push", len, 5);
    fork wr(mio_pkg::OFS_CTRL, 32'h0000_0004); width(mio_pkg::O_ITEM); join
    chk("item dwell", len, 3);
    sw <= 10'h0A0;
    width(mio_pkg::O_SHEAR);
    chk("hand cut", len, 5);
    sw <= 10'h0C0;
    width(mio_pkg::O_PRESS);
    chk("hand press", len, 50);
    sw <= 10'h090;
    wt(15);
    wr(mio_pkg::OFS_SDWELL, 32'h0000_0009);
    rc("locked dwell", mio_pkg::OFS_SDWELL, 32'h0000_0005);
    rc("lock error", mio_pkg::OFS_STATUS, 32'h0040_0090);
    wr(mio_pkg::OFS_STATUS, 32'h0040_0000);
    rc("error clear", mio_pkg::OFS_STATUS, 32'h0000_0090);
    wr(mio_pkg::OFS_FMT, 32'h0000_0001);
    wr(mio_pkg::OFS_FMT, 32'h0000_0002);
    rc("format", mio_pkg::OFS_FMT, 32'h0000_0003);
    wr(mio_pkg::OFS_HALT, 32'h0005_0010);
    rc("halt", mio_pkg::OFS_HALT, 32'h0005_0010);
    wr(mio_pkg::OFS_TIME, 32'h0003_0205);
    rc("time set", mio_pkg::OFS_TIME, 32'h0003_0205);
    wt(25);
    rc("time run", mio_pkg::OFS_TIME, 32'h0003_0206);
    wr(mio_pkg::OFS_CTRL, 32'h0000_0040);
    wr(mio_pkg::OFS_TIME, 32'h0009_0000);
    wb(1'b0, mio_pkg::OFS_TIME, 32'h0000_0000);
    chk("local time", q & 32'h001F_0000, 32'h0003_0000);
    wr(mio_pkg::OFS_HTIME, 32'h0007_0000);
    wb(1'b0, mio_pkg::OFS_TIME, 32'h0000_0000);
    chk("host time", q & 32'h001F_0000, 32'h0007_0000);
    rc("unmapped", 8'h3C, 32'h0000_0000);
    print_verdict();
  end
endmodule : machine_io_control_bench
